// ===== core/ivs_regs.svh
// Register offsets, reset values and vector constants of the interrupt vector sequencer
`ifndef IVS_REGS_SVH
`define IVS_REGS_SVH
`define IVS_ADDR_KEY_IRQ_SELECT 16'hFF54
`define IVS_ADDR_KEY_INPUT_COMPARE 16'hFF55
`define IVS_ADDR_FACTOR 16'hFF60
`define IVS_ADDR_MASK 16'hFF61
`define IVS_ADDR_STATUS 16'hFF62
`define IVS_ADDR_SP_ONE 16'hFF63
`define IVS_ADDR_SP_TWO 16'hFF64
`define IVS_ADDR_CORE 16'hFF65
`define IVS_RST_KEY_IRQ_SELECT 4'h0
`define IVS_RST_KEY_INPUT_COMPARE 4'hF
`define IVS_RST_MASK 5'h00
`define IVS_RST_SP 8'h00
`define IVS_VECTOR_PAGE 12'h010
`define IVS_VEC_WDT 4'h0
`define IVS_VEC_PTM 4'h2
`define IVS_VEC_SIF 4'h4
`define IVS_VEC_KEY 4'h6
`define IVS_VEC_CLK 4'h8
`define IVS_VEC_SWT 4'hA
`define IVS_STACK_BASE 16'h0000
`endif

// ===== core/ivs_pkg.sv
// Types shared by the interrupt vector sequencer
package ivs_pkg;
    typedef enum logic [5:0] {
        IVS_IDLE = 6'b000001,
        IVS_WAIT = 6'b000010,
        IVS_FLAGS = 6'b000100,
        IVS_PUSH = 6'b001000,
        IVS_VECTOR = 6'b010000,
        IVS_DONE = 6'b100000
    } ivs_state_t;
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ivs_ram_req_t;
    typedef struct packed {
        logic load;
        logic [15:0] pc;
    } ivs_pc_load_t;
endpackage : ivs_pkg

// ===== core/ivs_key_detect.sv
// Key input change detector: flags an edge on each selected key pin
`timescale 1ns/100ps
module ivs_key_detect
    import ivs_pkg::*;
#(
    parameter int KEYS = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [KEYS-1:0] key_input_pins,
    input wire logic [KEYS-1:0] select,
    input wire logic [KEYS-1:0] compare,
    output logic [KEYS-1:0] edge_pulse
);
    logic [KEYS-1:0] match_q;
    logic [KEYS-1:0] match;
    // An edge is a loss of agreement between pin and compare level
    assign match = ~(key_input_pins ^ compare);
    genvar i;
    generate
        for (i = 0; i < KEYS; i++) begin : g_key
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    match_q[i] <= 1'b1;
                    edge_pulse[i] <= 1'b0;
                end else begin
                    match_q[i] <= match[i];
                    // Only a match-to-mismatch change counts, and only if selected
                    edge_pulse[i] <= select[i] & match_q[i] & ~match[i];
                end
            end
        end
    endgenerate
endmodule : ivs_key_detect

// ===== core/ivs_priority.sv
// Fixed priority encoder for the six interrupt classes
`timescale 1ns/100ps
`include "ivs_regs.svh"
module ivs_priority
    import ivs_pkg::*;
(
    input wire logic [5:0] req,
    output logic any,
    output logic [3:0] vec_low
);
    // Watchdog first, stopwatch last
    assign any = |req;
    assign vec_low = req[0] ? `IVS_VEC_WDT :
                     req[1] ? `IVS_VEC_PTM :
                     req[2] ? `IVS_VEC_SIF :
                     req[3] ? `IVS_VEC_KEY :
                     req[4] ? `IVS_VEC_CLK :
                     `IVS_VEC_SWT;
endmodule : ivs_priority

// ===== core/ivs_sequencer.sv
// Interrupt vector sequencer: request gating, entry sequence and APB registers
`timescale 1ns/100ps
`include "ivs_regs.svh"
module ivs_sequencer
    import ivs_pkg::*;
#(
    parameter int KEYS = 4
) (
    // Clock and asynchronous reset
    input wire logic mclk,
    input wire logic resetn,

    // APB slave side; paddr is the byte address of the register
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Sources: one-cycle event pulses, a held watchdog level and the key pins
    input wire logic wdt_req,
    input wire logic ptm_event,
    input wire logic sif_event,
    input wire logic clk_event,
    input wire logic swt_event,
    input wire logic [KEYS-1:0] key_input_pins,

    // Core side: instruction boundary, next pc, flags and the enable instruction
    input wire logic instr_done,
    input wire logic [15:0] core_pc,
    input wire logic [7:0] core_flags,
    input wire logic core_ei_set,
    // Entry results: enable flag, saved flags, stack push, vector load, status
    output logic core_ei,
    output logic [7:0] saved_flags,
    output ivs_ram_req_t ram_req,
    output ivs_pc_load_t pc_load,
    output logic in_entry,
    output logic irq
);
    // Register file
    // Factor and mask: one bit per maskable class, in the order
    // ptm, sif, key, clk, swt
    // Set flags: which half of the stack pointer pair was written
    // since the last complete pair
    logic [KEYS-1:0] key_irq_select;
    logic [KEYS-1:0] key_input_compare;
    logic [4:0] factor;
    logic [4:0] mask;
    logic [7:0] stack_pointer_one;
    logic [7:0] stack_pointer_two;
    logic sp_one_set;
    logic sp_two_set;
    logic ei_flag;
    ivs_state_t state;
    ivs_state_t next_state;
    logic [3:0] latched_vec;
    logic [KEYS-1:0] key_edge;

    // APB decode; single access cycle so pready is always high
    // No wait states, so no transfer can stall the entry sequence
    // Full address compare: an alias would let a stray write reach
    // the stack pointers and block every interrupt
    // No byte lanes; each register takes the low bits of one word
    logic wr_en;
    logic rd_en;
    logic hit_sel;
    logic hit_cmp;
    logic hit_fac;
    logic hit_msk;
    logic hit_sts;
    logic hit_sp1;
    logic hit_sp2;
    logic hit_core;
    logic mapped;
    assign wr_en = psel & penable & pwrite;
    // Read data captured in the setup cycle, so it already stands
    // when the master samples it with pready in the access cycle
    assign rd_en = psel & ~penable & ~pwrite;
    assign hit_sel = paddr == `IVS_ADDR_KEY_IRQ_SELECT;
    assign hit_cmp = paddr == `IVS_ADDR_KEY_INPUT_COMPARE;
    assign hit_fac = paddr == `IVS_ADDR_FACTOR;
    assign hit_msk = paddr == `IVS_ADDR_MASK;
    assign hit_sts = paddr == `IVS_ADDR_STATUS;
    assign hit_sp1 = paddr == `IVS_ADDR_SP_ONE;
    assign hit_sp2 = paddr == `IVS_ADDR_SP_TWO;
    assign hit_core = paddr == `IVS_ADDR_CORE;
    assign mapped = hit_sel | hit_cmp | hit_fac | hit_msk | hit_sts | hit_sp1 | hit_sp2
                    | hit_core;
    // Always ready; a slower register would need a wait state here
    // and the master would simply hold its request
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped; // Unmapped addresses answer with an error

    // Key change detector
    // Pins taken as synchronous; only a departure from the compare
    // level on a selected pin is reported, one pulse per departure
    ivs_key_detect #(.KEYS(KEYS)) u_keys (
        .mclk(mclk),
        .resetn(resetn),
        .key_input_pins(key_input_pins),
        .select(key_irq_select),
        .compare(key_input_compare),
        .edge_pulse(key_edge)
    );

    // Source events in factor order: ptm, sif, key, clk, swt
    // The four key pins share one factor bit, as they share one vector
    // Events are pulses, so a source never holds a factor bit set itself
    logic [4:0] events;
    assign events = {swt_event, clk_event, |key_edge, sif_event, ptm_event};

    // Gating: both stack pointers must be set before anything is taken
    // The watchdog bypasses enable flag and mask, but not this gate:
    // before the pointers are valid a push would land at a random place
    // Limitation: the watchdog source must hold its level until entry
    logic sp_ready;
    logic [4:0] pending;
    logic [5:0] req;
    logic req_any;
    logic [3:0] req_vec;
    assign sp_ready = sp_one_set & sp_two_set;
    assign pending = factor & mask & {5{ei_flag}};
    assign req = {pending, wdt_req} & {6{sp_ready}};

    // Fixed priority pick among the gated requests; the winner is
    // latched at acceptance, not re-evaluated during the sequence
    ivs_priority u_prio (
        .req(req),
        .any(req_any),
        .vec_low(req_vec)
    );

    // Status word for software and the level interrupt output
    // The irq level ignores the enable flag on purpose, so a poller
    // still sees pending unmasked factors while interrupts are off
    // in_entry is high from the cycle after acceptance to the end of DONE
    logic [31:0] status_word;
    assign status_word = {24'h000000, in_entry, ei_flag, sp_two_set, sp_one_set, 4'h0};
    assign irq = |(factor & mask);
    assign core_ei = ei_flag;
    assign in_entry = state != IVS_IDLE;

    // Read mux
    // Unused bits and unmapped addresses read as zero; an unmapped
    // read also answers with pslverr
    logic [31:0] rd_mux;
    assign rd_mux = hit_sel ? {28'h0000000, key_irq_select} :
                    hit_cmp ? {28'h0000000, key_input_compare} :
                    hit_fac ? {27'h0000000, factor} :
                    hit_msk ? {27'h0000000, mask} :
                    hit_sts ? status_word :
                    hit_sp1 ? {24'h000000, stack_pointer_one} :
                    hit_sp2 ? {24'h000000, stack_pointer_two} :
                    hit_core ? {31'h00000000, ei_flag} :
                    32'h00000000;

    // Read data registered in the setup cycle
    // A flag that changes between setup and access shows on the next read
    // Holds its value until the next read, writes leave it alone
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= rd_mux;
        end
    end

    // Key configuration and mask registers
    // Writes land at the access edge; a new select or compare level
    // acts from the next cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            key_irq_select <= `IVS_RST_KEY_IRQ_SELECT;
            key_input_compare <= `IVS_RST_KEY_INPUT_COMPARE;
            mask <= `IVS_RST_MASK;
        end else if (wr_en) begin
            if (hit_sel) key_irq_select <= pwdata[KEYS-1:0];
            if (hit_cmp) key_input_compare <= pwdata[KEYS-1:0];
            if (hit_msk) mask <= pwdata[4:0];
        end
    end

    // Factor flags: a new event wins over a same-cycle write-one clear
    // Losing an event to a clear would drop an interrupt for good,
    // while a late clear only costs software one more write
    // Writing zero bits leaves the matching flags untouched
    logic [4:0] clr_mask;
    assign clr_mask = (wr_en & hit_fac) ? pwdata[4:0] : 5'h00;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            factor <= 5'h00;
        end else begin
            factor <= (factor & ~clr_mask) | events;
        end
    end

    // Stack pointers; rewriting one half of a complete pair blocks
    // every request until the other half is written as well
    // Only the first pointer moves on a push; the second belongs to
    // the core's data stack and is never touched here
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stack_pointer_one <= `IVS_RST_SP;
            stack_pointer_two <= `IVS_RST_SP;
            sp_one_set <= 1'b0;
            sp_two_set <= 1'b0;
        end else if (wr_en && hit_sp1) begin
            stack_pointer_one <= pwdata[7:0];
            sp_one_set <= 1'b1;
            sp_two_set <= sp_two_set & ~sp_one_set;
        end else if (wr_en && hit_sp2) begin
            stack_pointer_two <= pwdata[7:0];
            sp_two_set <= 1'b1;
            sp_one_set <= sp_one_set & ~sp_two_set;
        end else if (state == IVS_PUSH) begin
            stack_pointer_one <= stack_pointer_one - 8'h01;
        end
    end

    // Entry sequence state
    // IDLE: waits for a gated request
    // WAIT: the current instruction runs to its end
    // FLAGS: flags saved, enable cleared
    // PUSH: return address written; VECTOR: program counter loaded
    // DONE: one cycle for the core to fetch before a new acceptance
    always_comb begin
        next_state = state;
        unique case (state)
            IVS_IDLE: if (req_any) next_state = IVS_WAIT;
            IVS_WAIT: if (instr_done) next_state = IVS_FLAGS;
            IVS_FLAGS: next_state = IVS_PUSH;
            IVS_PUSH: next_state = IVS_VECTOR;
            IVS_VECTOR: next_state = IVS_DONE;
            IVS_DONE: next_state = IVS_IDLE;
        endcase
    end

    // Vector latched at acceptance so a later request cannot change it
    // A higher source arriving during WAIT is served by the next entry
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= IVS_IDLE;
            latched_vec <= `IVS_VEC_WDT;
        end else begin
            state <= next_state;
            if (state == IVS_IDLE && req_any) latched_vec <= req_vec;
        end
    end

    // Interrupt enable flag: core sets it, entry clears it, a software write loads pwdata[0]
    // Entry clearing has precedence, so an enable instruction ending
    // in the same cycle cannot open the way to a nested entry
    // Saved flags hold until the next entry overwrites them
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ei_flag <= 1'b0;
            saved_flags <= 8'h00;
        end else if (state == IVS_FLAGS) begin
            saved_flags <= core_flags;
            ei_flag <= 1'b0;
        end else if (core_ei_set) begin
            ei_flag <= 1'b1;
        end else if (wr_en && hit_core) begin
            ei_flag <= pwdata[0];
        end
    end

    // Stack push of the return address and the program counter load
    // Both outputs are registered one cycle behind their states; the
    // push uses the pointer value from before its decrement
    // The strobes stand for exactly one cycle each
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ram_req <= '0;
            pc_load <= '0;
        end else begin
            ram_req.we <= state == IVS_PUSH;
            ram_req.addr <= `IVS_STACK_BASE + {8'h00, stack_pointer_one};
            ram_req.wdata <= core_pc;
            pc_load.load <= state == IVS_VECTOR;
            pc_load.pc <= {`IVS_VECTOR_PAGE, latched_vec};
        end
    end
endmodule : ivs_sequencer

// ===== testbench/ivs_props.sv
// Port checker of the interrupt vector sequencer
`timescale 1ns/100ps
`include "ivs_regs.svh"
module ivs_props
    import ivs_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic wdt_req,
    input wire logic instr_done,
    input wire logic [15:0] core_pc,
    input wire logic [7:0] core_flags,
    input wire logic core_ei,
    input wire logic [7:0] saved_flags,
    input wire ivs_ram_req_t ram_req,
    input wire ivs_pc_load_t pc_load,
    input wire logic in_entry,
    input wire logic irq
);
    logic [1:0] sp_ok;
    wire sp_wr = psel && penable && pwrite;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Stack pointer pair tracking; a lone rewrite of an armed pair disarms the other
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sp_ok <= 2'h0;
        end else if (sp_wr && paddr == `IVS_ADDR_SP_ONE) begin
            sp_ok <= (sp_ok == 2'h3) ? 2'h1 : (sp_ok | 2'h1);
        end else if (sp_wr && paddr == `IVS_ADDR_SP_TWO) begin
            sp_ok <= (sp_ok == 2'h3) ? 2'h2 : (sp_ok | 2'h2);
        end
    end
    wait_done_a: assert property (ram_req.we |-> $past(instr_done, 3))
        else $error("push without a finished instruction");
    flags_saved_a: assert property (ram_req.we |-> saved_flags == core_flags && !core_ei)
        else $error("flags not saved or enable not cleared");
    push_pc_a: assert property (ram_req.we |-> ram_req.wdata == core_pc)
        else $error("pushed value is not the next pc");
    push_then_vec_a: assert property (ram_req.we |=> pc_load.load)
        else $error("vector load does not follow push");
    vec_page_a: assert property (pc_load.load |-> pc_load.pc[15:4] == 12'h010 &&
        pc_load.pc[3:0] inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA})
        else $error("vector outside the vector page");
    nmi_vector_a: assert property (pc_load.load && wdt_req |-> pc_load.pc == 16'h0100)
        else $error("watchdog vector wrong");
    gate_ei_a: assert property ($rose(in_entry) && !$past(wdt_req) |->
        $past(core_ei) && $past(irq))
        else $error("maskable entry without enable");
    sp_pair_a: assert property ($rose(in_entry) |-> sp_ok == 2'h3)
        else $error("entry before both stack pointers set");
    cover property (pc_load.load && wdt_req);
    cover property ($rose(in_entry) && core_ei);
    cover property (ram_req.we && !wdt_req);
endmodule : ivs_props

bind ivs_sequencer ivs_props i_props (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .wdt_req(wdt_req),
    .instr_done(instr_done), .core_pc(core_pc), .core_flags(core_flags), .core_ei(core_ei),
    .saved_flags(saved_flags), .ram_req(ram_req), .pc_load(pc_load), .in_entry(in_entry),
    .irq(irq));

// ===== testbench/ivs_core_model.sv
// Processor core model: instruction pacing, program counter, flags and stack
`timescale 1ns/100ps
module ivs_core_model
    import ivs_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] pace,
    input wire logic in_entry,
    input wire ivs_ram_req_t ram_req,
    input wire ivs_pc_load_t pc_load,
    output logic instr_done,
    output logic [15:0] core_pc,
    output logic [7:0] core_flags,
    output logic [15:0] push_addr
);
    logic [3:0] cnt;
    assign core_flags = core_pc[7:0] ^ 8'h3C;
    // Instructions end every pace+1 cycles; the pc holds still while entry runs
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 4'h0;
            instr_done <= 1'b0;
            core_pc <= 16'h0200;
        end else begin
            cnt <= (cnt >= pace) ? 4'h0 : cnt + 4'h1;
            instr_done <= (cnt >= pace);
            if (pc_load.load) begin
                core_pc <= pc_load.pc;
            end else if (instr_done && !in_entry) begin
                core_pc <= core_pc + 16'h0001;
            end
        end
    end
    // Stack RAM side keeps the address of the latest push
    always_ff @(posedge mclk) begin
        if (ram_req.we) begin
            push_addr <= ram_req.addr;
        end
    end
endmodule : ivs_core_model

// ===== testbench/test_interrupt_vector_sequencer.sv
// Self-checking bench of the interrupt vector sequencer
`timescale 1ns/100ps
`include "ivs_regs.svh"
module test_interrupt_vector_sequencer
    import ivs_pkg::*;
;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, perr, wdt_req;
    logic core_ei, in_entry, irq, instr_done;
    logic [15:0] paddr, core_pc, push_addr, pc;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] ev, keys, pace;
    logic [7:0] core_flags;
    ivs_ram_req_t ram_req;
    ivs_pc_load_t pc_load;
    int error_cnt, n_tests, cyc;
    logic [15:0] vecs [5] = '{16'h0102, 16'h0104, 16'h0106, 16'h0108, 16'h010A};
    ivs_sequencer i_dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdt_req(wdt_req), .ptm_event(ev[0]), .sif_event(ev[1]),
        .clk_event(ev[2]), .swt_event(ev[3]), .key_input_pins(keys),
        .instr_done(instr_done), .core_pc(core_pc), .core_flags(core_flags),
        .core_ei_set(1'b0), .core_ei(core_ei), .saved_flags(), .ram_req(ram_req),
        .pc_load(pc_load), .in_entry(in_entry), .irq(irq));
    ivs_core_model i_core (.mclk(mclk), .resetn(resetn), .pace(pace), .in_entry(in_entry),
        .ram_req(ram_req), .pc_load(pc_load), .instr_done(instr_done), .core_pc(core_pc),
        .core_flags(core_flags), .push_addr(push_addr));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One APB transfer; read data and error taken at the pready edge, then one idle cycle
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        perr = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic wait_load();
        do @(posedge mclk); while (pc_load.load !== 1'b1);
        pc = pc_load.pc;
    endtask : wait_load
    task automatic t_regs();
        apb(1'b0, `IVS_ADDR_KEY_IRQ_SELECT, 32'h0);
        chk("select reset", 32'h0, rd);
        apb(1'b0, `IVS_ADDR_KEY_INPUT_COMPARE, 32'h0);
        chk("compare reset", 32'hF, rd);
        apb(1'b1, `IVS_ADDR_KEY_IRQ_SELECT, 32'h5);
        apb(1'b0, `IVS_ADDR_KEY_IRQ_SELECT, 32'h0);
        chk("select", 32'h5, rd);
        apb(1'b0, 16'hFF70, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, perr});
        $display("register test done");
    endtask : t_regs
    // Watchdog stays blocked until both stack pointers are written, then wins with EI low
    task automatic t_sp_gate();
        wdt_req <= 1'b1;
        repeat (20) @(posedge mclk);
        chk("entry no sp", 32'h0, {31'h0, in_entry});
        apb(1'b1, `IVS_ADDR_SP_ONE, 32'h80);
        repeat (20) @(posedge mclk);
        chk("entry one sp", 32'h0, {31'h0, in_entry});
        apb(1'b1, `IVS_ADDR_SP_TWO, 32'h90);
        wait_load();
        wdt_req <= 1'b0;
        chk("nmi vector", 32'h0100, {16'h0, pc});
        #1;
        chk("push address", 32'h0080, {16'h0, push_addr});
        repeat (4) @(posedge mclk);
        $display("stack pointer test done");
    endtask : t_sp_gate
    // All five maskable sources pending; served one by one in priority order
    task automatic t_prio();
        pace <= 4'h7;
        apb(1'b1, `IVS_ADDR_CORE, 32'h1);
        ev <= 4'hF;
        keys <= 4'hE;
        @(posedge mclk);
        ev <= 4'h0;
        repeat (20) @(posedge mclk);
        chk("masked entry", 32'h0, {30'h0, irq, in_entry});
        apb(1'b1, `IVS_ADDR_MASK, 32'h1F);
        for (int i = 0; i < 5; i++) begin
            wait_load();
            chk("vector", {16'h0, vecs[i]}, {16'h0, pc});
            apb(1'b0, `IVS_ADDR_CORE, 32'h0);
            chk("enable flag", 32'h0, {31'h0, rd[0]});
            apb(1'b1, `IVS_ADDR_FACTOR, 32'h1 << i);
            apb(1'b1, `IVS_ADDR_CORE, 32'h1);
        end
        repeat (20) @(posedge mclk);
        chk("all cleared", 32'h0, {30'h0, irq, in_entry});
        $display("priority test done");
    endtask : t_prio
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    // Cycle ceiling cuts a hung wait short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // Reset, then the scenarios in turn
    initial begin
        {resetn, psel, penable, pwrite, wdt_req} = 5'h00;
        paddr = 16'h0;
        pwdata = 32'h0;
        {ev, keys, pace} = 12'h0F1;
        {error_cnt, n_tests, cyc} = '0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_sp_gate();
        t_prio();
        close_out();
    end
endmodule : test_interrupt_vector_sequencer
